/* hdl/pbs_seq.sv */
// bus-state sequencer with per-cycle address pipelining
`timescale 1ns/100ps
module pbs_seq (
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       clock_doubled_i,
    input  wire logic                       req_valid_i,
    output logic                            req_ready_o,
    input  wire logic [pbs_pkg::ADDR_W-1:0] req_addr_i,
    input  wire logic [pbs_pkg::BE_W-1:0]   req_be_n_i,
    input  wire logic                       req_write_i,
    input  wire logic                       req_mem_i,
    input  wire logic                       req_data_cyc_i,
    input  wire logic [pbs_pkg::DATA_W-1:0] req_wdata_i,
    output logic                            rd_valid_o,
    input  wire logic                       rd_ready_i,
    output logic [pbs_pkg::DATA_W-1:0]      rd_data_o,
    input  wire logic                       next_address_request_n_i,
    input  wire logic                       ready_n_i,
    input  wire logic                       hold_request_i,
    output logic                            hold_grant_o,
    output logic                            address_strobe_n_o,
    output logic [pbs_pkg::ADDR_W-1:0]      word_address_o,
    output logic [pbs_pkg::BE_W-1:0]        byte_enables_n_o,
    output logic                            write_read_o,
    output logic                            mem_io_o,
    output logic                            data_ctrl_o,
    output logic [pbs_pkg::DATA_W-1:0]      data_o,
    output logic                            data_oe_o,
    input  wire logic [pbs_pkg::DATA_W-1:0] data_i
);
    localparam int AW = pbs_pkg::ADDR_W;
    localparam int DW = pbs_pkg::DATA_W;
    localparam int BW = pbs_pkg::BE_W;

    pbs_pkg::pbs_state_t state_reg;
    pbs_pkg::pbs_state_t state_next;
    logic          phase_reg;
    logic          phase_next;
    logic          na_seen_reg;
    logic          na_seen_next;
    // one-entry holding register for the internal request
    logic          pend_v_reg;
    logic          pend_v_next;
    logic [AW-1:0] pend_addr_reg;
    logic [BW-1:0] pend_be_reg;
    logic          pend_wr_reg;
    logic          pend_mem_reg;
    logic          pend_dc_reg;
    logic [DW-1:0] pend_wd_reg;
    logic          req_rdy_reg;
    // bus-facing address group
    logic          ads_n_reg;
    logic          ads_n_next;
    logic [AW-1:0] addr_reg;
    logic [BW-1:0] be_reg;
    logic          wr_reg;
    logic          mem_reg;
    logic          dc_reg;
    // cycle in progress and the one already presented behind it
    logic          cur_wr_reg;
    logic          cur_wr_next;
    logic [DW-1:0] cur_wd_reg;
    logic [DW-1:0] cur_wd_next;
    logic          pipe_wr_reg;
    logic [DW-1:0] pipe_wd_reg;
    logic          rd_busy_reg;
    logic          rd_busy_next;
    logic [DW-1:0] dout_reg;
    logic [DW-1:0] dout_next;
    logic          oe_reg;
    logic          oe_next;
    logic          wr_hold_reg;
    logic          wr_hold_next;
    logic          hold_reg;

    logic tick;
    logic na_strobe;
    logic na_now;
    logic rdy;
    logic pending;
    logic present;
    logic ack;
    logic sampling;
    logic first_state;

    pbs_stream_if #(.W(DW)) cap_s ();
    pbs_stream_if #(.W(DW)) rd_s ();

    assign rdy       = !ready_n_i;
    // a bus state ends on phase two, or on every clock when doubled
    assign tick      = clock_doubled_i || (phase_reg == pbs_pkg::PHASE_TWO);
    assign phase_next = clock_doubled_i ? pbs_pkg::PHASE_ONE : !phase_reg;
    // sampled at the end of phase one, i.e. where phase two begins
    assign na_strobe = clock_doubled_i || (phase_reg == pbs_pkg::PHASE_ONE);
    // the second nonpipelined, pipelined-first and no-request states are the only ones that sample next-address
    assign sampling  = (state_reg == pbs_pkg::ST_CYC_SECOND)
                    || (state_reg == pbs_pkg::ST_PIPE_FIRST)
                    || (state_reg == pbs_pkg::ST_PIPE_NOREQ);
    assign na_now    = na_seen_reg
                    || (na_strobe && sampling
                        && !next_address_request_n_i);
    // a read may only start when its captured word is sure of a slot
    assign pending   = pend_v_reg
                    && (pend_wr_reg || (!rd_busy_reg && cap_s.ready));
    assign first_state = (state_reg == pbs_pkg::ST_CYC_FIRST)
                      || (state_reg == pbs_pkg::ST_PIPE_FIRST);

    always_comb
    begin
        state_next   = state_reg;
        na_seen_next = na_seen_reg;
        present      = 1'b0;
        ack          = 1'b0;
        cur_wr_next  = cur_wr_reg;
        cur_wd_next  = cur_wd_reg;
        if (na_strobe && sampling && !next_address_request_n_i)
            na_seen_next = 1'b1;
        if (tick)
        begin
            case (state_reg)
                pbs_pkg::ST_IDLE:
                begin
                    if (hold_request_i)
                        state_next = pbs_pkg::ST_HOLD;
                    else if (pending)
                    begin
                        // never pipelined straight out of idle
                        state_next = pbs_pkg::ST_CYC_FIRST;
                        present    = 1'b1;
                    end
                end
                pbs_pkg::ST_HOLD:
                begin
                    if (!hold_request_i)
                        state_next = pbs_pkg::ST_IDLE;
                end
                pbs_pkg::ST_CYC_FIRST:
                    state_next = pbs_pkg::ST_CYC_SECOND;
                pbs_pkg::ST_CYC_SECOND:
                begin
                    if (rdy)
                        ack = 1'b1;
                    else if (na_now && pending)
                    begin
                        state_next = pbs_pkg::ST_PIPE_ADDR;
                        present    = 1'b1;
                    end
                    else if (na_now)
                        state_next = pbs_pkg::ST_PIPE_NOREQ;
                end
                pbs_pkg::ST_PIPE_FIRST:
                begin
                    // ready at the end of this state is not an answer
                    if (!pending)
                        state_next = pbs_pkg::ST_PIPE_NOREQ;
                    else if (na_now)
                    begin
                        state_next = pbs_pkg::ST_PIPE_ADDR;
                        present    = 1'b1;
                    end
                    else
                        state_next = pbs_pkg::ST_CYC_SECOND;
                end
                pbs_pkg::ST_PIPE_ADDR:
                begin
                    // only one following cycle can be out at a time
                    if (rdy)
                    begin
                        ack          = 1'b1;
                        state_next   = pbs_pkg::ST_PIPE_FIRST;
                        na_seen_next = 1'b0;
                        cur_wr_next  = pipe_wr_reg;
                        cur_wd_next  = pipe_wd_reg;
                    end
                end
                pbs_pkg::ST_PIPE_NOREQ:
                begin
                    if (rdy)
                        ack = 1'b1;
                    else if (pending)
                    begin
                        state_next = pbs_pkg::ST_PIPE_ADDR;
                        present    = 1'b1;
                    end
                end
                default:
                    state_next = pbs_pkg::ST_IDLE;
            endcase
            // end of a cycle whose next address was not yet presented
            if (ack && (state_reg != pbs_pkg::ST_PIPE_ADDR))
            begin
                na_seen_next = 1'b0;
                if (hold_request_i)
                    state_next = pbs_pkg::ST_HOLD;
                else if (pending)
                begin
                    state_next = pbs_pkg::ST_CYC_FIRST;
                    present    = 1'b1;
                end
                else
                    state_next = pbs_pkg::ST_IDLE;
            end
        end
        if (present && (state_next == pbs_pkg::ST_CYC_FIRST))
        begin
            cur_wr_next = pend_wr_reg;
            cur_wd_next = pend_wd_reg;
        end
    end

    // strobe only in the first nonpipelined state and while the
    // pipelined address is out; the system reads pipelining from it
    assign ads_n_next = !((state_next == pbs_pkg::ST_CYC_FIRST)
                       || (state_next == pbs_pkg::ST_PIPE_ADDR));

    always_comb
    begin
        pend_v_next  = pend_v_reg;
        rd_busy_next = rd_busy_reg;
        if (present)
        begin
            pend_v_next = 1'b0;
            if (!pend_wr_reg)
                rd_busy_next = 1'b1;
        end
        if (ack && !cur_wr_reg)
            rd_busy_next = present && !pend_wr_reg;
        if (!pend_v_next && req_valid_i && req_rdy_reg)
            pend_v_next = 1'b1;
    end

    // write data: from phase two of the first state, held one phase
    // past the acknowledge so the target sees hold time
    always_comb
    begin
        wr_hold_next = ack && cur_wr_reg;
        if (wr_hold_next)
            dout_next = dout_reg;
        else
            dout_next = cur_wd_next;
        oe_next = wr_hold_next;
        if (cur_wr_next)
        begin
            case (state_next)
                pbs_pkg::ST_CYC_FIRST,
                pbs_pkg::ST_PIPE_FIRST:
                    oe_next = oe_next || (phase_next == pbs_pkg::PHASE_TWO)
                           || clock_doubled_i;
                pbs_pkg::ST_CYC_SECOND,
                pbs_pkg::ST_PIPE_ADDR,
                pbs_pkg::ST_PIPE_NOREQ:
                    oe_next = 1'b1;
                default:
                    oe_next = oe_next;
            endcase
        end
        if (first_state && !tick && !cur_wr_reg)
            oe_next = wr_hold_next;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg   <= pbs_pkg::ST_IDLE;
            phase_reg   <= pbs_pkg::PHASE_ONE;
            na_seen_reg <= 1'b0;
            ads_n_reg   <= pbs_pkg::ADS_N_RST;
            hold_reg    <= 1'b0;
            cur_wr_reg  <= 1'b0;
            cur_wd_reg  <= '0;
            rd_busy_reg <= 1'b0;
            dout_reg    <= '0;
            oe_reg      <= 1'b0;
            wr_hold_reg <= 1'b0;
            pend_v_reg  <= 1'b0;
            req_rdy_reg <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            phase_reg   <= phase_next;
            na_seen_reg <= na_seen_next;
            ads_n_reg   <= ads_n_next;
            hold_reg    <= (state_next == pbs_pkg::ST_HOLD);
            cur_wr_reg  <= cur_wr_next;
            cur_wd_reg  <= cur_wd_next;
            rd_busy_reg <= rd_busy_next;
            dout_reg    <= dout_next;
            oe_reg      <= oe_next;
            wr_hold_reg <= wr_hold_next;
            pend_v_reg  <= pend_v_next;
            req_rdy_reg <= !pend_v_next;
        end
    end

    // data registers only load on their strobes, no reset needed on
    // the payload beyond a known start
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_reg      <= '0;
            be_reg        <= pbs_pkg::BE_N_RST;
            wr_reg        <= 1'b0;
            mem_reg       <= 1'b0;
            dc_reg        <= 1'b0;
            pipe_wr_reg   <= 1'b0;
            pipe_wd_reg   <= '0;
            pend_addr_reg <= '0;
            pend_be_reg   <= pbs_pkg::BE_N_RST;
            pend_wr_reg   <= 1'b0;
            pend_mem_reg  <= 1'b0;
            pend_dc_reg   <= 1'b0;
            pend_wd_reg   <= '0;
        end
        else
        begin
            if (present)
            begin
                addr_reg    <= pend_addr_reg;
                be_reg      <= pend_be_reg;
                wr_reg      <= pend_wr_reg;
                mem_reg     <= pend_mem_reg;
                dc_reg      <= pend_dc_reg;
                pipe_wr_reg <= pend_wr_reg;
                pipe_wd_reg <= pend_wd_reg;
            end
            if (!pend_v_reg && req_valid_i && req_rdy_reg)
            begin
                pend_addr_reg <= req_addr_i;
                pend_be_reg   <= req_be_n_i;
                pend_wr_reg   <= req_write_i;
                pend_mem_reg  <= req_mem_i;
                pend_dc_reg   <= req_data_cyc_i;
                pend_wd_reg   <= req_wdata_i;
            end
        end
    end

    // read data taken from the pins on the acknowledging edge
    assign cap_s.valid = ack && !cur_wr_reg;
    assign cap_s.data  = data_i;

    pbs_buf #(
        .W     (DW),
        .DEPTH (pbs_pkg::BUF_DEPTH)
    ) u_rd_buf (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .in_s      (cap_s),
        .out_s     (rd_s)
    );

    assign rd_s.ready         = rd_ready_i;
    assign rd_valid_o         = rd_s.valid;
    assign rd_data_o          = rd_s.data;
    assign req_ready_o        = req_rdy_reg;
    assign hold_grant_o       = hold_reg;
    assign address_strobe_n_o = ads_n_reg;
    assign word_address_o     = addr_reg;
    assign byte_enables_n_o   = be_reg;
    assign write_read_o       = wr_reg;
    assign mem_io_o           = mem_reg;
    assign data_ctrl_o        = dc_reg;
    assign data_o             = dout_reg;
    assign data_oe_o          = oe_reg;
endmodule

/* hdl/pbs_pkg.sv */
// constants and types for the pipelined address bus sequencer
// Summary of operation
// - next-address sampled end of phase one; second, pipelined-first and no-request states only
// - pipelined address driven early with strobe
// - pipelined first state follows presenting cycle
// - request plus pending goes to wait-with-address
// - nothing pending goes to no-request wait
// - ready ignored in pipelined first state
// - reads float data, capture on ready
// - write data from phase two, held after
// - wait states repeat while ready inactive
// - strobe and address held; repeat requests ignored
// - late request in second state starts pipelining
// - late internal request adds wait, then presents
// - first cycle after idle, hold, reset nonpipelined
// - next-address sampled each phase-one end of second, pipelined-first and no-request states
// - no strobe or address in no-request wait
// - hold state asserts hold grant
// - after acknowledge: next cycle, idle or hold
// - bus state is two clocks, one when doubled
package pbs_pkg;
    localparam int ADDR_W    = 30;
    localparam int BE_W      = 4;
    localparam int DATA_W    = 32;
    localparam int BUF_DEPTH = 2;

    localparam logic       ADS_N_RST  = 1'b1;
    localparam logic [3:0] BE_N_RST   = 4'hf;
    localparam logic       PHASE_ONE  = 1'b0;
    localparam logic       PHASE_TWO  = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE       = 3'h0,
        ST_CYC_FIRST  = 3'h1,
        ST_CYC_SECOND = 3'h2,
        ST_PIPE_FIRST = 3'h3,
        ST_PIPE_ADDR  = 3'h4,
        ST_PIPE_NOREQ = 3'h5,
        ST_HOLD       = 3'h6
    } pbs_state_t;
endpackage

/* hdl/pbs_stream_if.sv */
// valid/ready word stream between the sequencer and its buffer
`timescale 1ns/100ps
interface pbs_stream_if #(parameter int W = 32);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* hdl/pbs_buf.sv */
// two-entry buffer with registered outputs for captured read data
`timescale 1ns/100ps
module pbs_buf #(
    parameter int W     = 32,
    parameter int DEPTH = 2
) (
    input  wire logic  sys_clk_i,
    input  wire logic  rst_n_i,
    pbs_stream_if.snk  in_s,
    pbs_stream_if.src  out_s
);
    generate
        if (DEPTH != 2)
        begin : g_chk
            $error("pbs_buf only serves a depth of two");
        end
    endgenerate

    logic         head_v_reg;
    logic         head_v_next;
    logic         skid_v_reg;
    logic         skid_v_next;
    logic [W-1:0] head_reg;
    logic [W-1:0] head_next;
    logic [W-1:0] skid_reg;
    logic [W-1:0] skid_next;
    logic         in_rdy_reg;

    // ready is registered, so the skid entry absorbs a word that was
    // already on its way when the drain side stalled
    always_comb
    begin
        head_v_next = head_v_reg;
        skid_v_next = skid_v_reg;
        head_next   = head_reg;
        skid_next   = skid_reg;
        if (out_s.ready && head_v_reg)
        begin
            head_v_next = skid_v_reg;
            head_next   = skid_reg;
            skid_v_next = 1'b0;
        end
        if (in_s.valid && in_rdy_reg)
        begin
            if (!head_v_next)
            begin
                head_v_next = 1'b1;
                head_next   = in_s.data;
            end
            else
            begin
                skid_v_next = 1'b1;
                skid_next   = in_s.data;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            head_v_reg <= 1'b0;
            skid_v_reg <= 1'b0;
            head_reg   <= '0;
            skid_reg   <= '0;
            in_rdy_reg <= 1'b1;
        end
        else
        begin
            head_v_reg <= head_v_next;
            skid_v_reg <= skid_v_next;
            head_reg   <= head_next;
            skid_reg   <= skid_next;
            in_rdy_reg <= !skid_v_next;
        end
    end

    assign in_s.ready  = in_rdy_reg;
    assign out_s.valid = head_v_reg;
    assign out_s.data  = head_reg;
endmodule

/* tb/pbs_seq_properties.sv */
// concurrent checks on the sequencer's top-level ports
`timescale 1ns/100ps
module pbs_seq_checker (
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       clock_doubled_i,
    input  wire logic                       req_valid_i,
    input  wire logic                       req_ready_o,
    input  wire logic                       rd_valid_o,
    input  wire logic                       rd_ready_i,
    input  wire logic [pbs_pkg::DATA_W-1:0] rd_data_o,
    input  wire logic                       hold_request_i,
    input  wire logic                       hold_grant_o,
    input  wire logic                       address_strobe_n_o,
    input  wire logic [pbs_pkg::ADDR_W-1:0] word_address_o,
    input  wire logic                       write_read_o,
    input  wire logic                       data_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_taken;
        req_valid_i && req_ready_o;
    endsequence
    sequence s_present;
        ##[1:400] $fell(address_strobe_n_o);
    endsequence
    property p_addr_strobe;
        $changed(word_address_o) |-> $fell(address_strobe_n_o);
    endproperty
    property p_strobe_state;
        $fell(address_strobe_n_o) && !clock_doubled_i
            |=> !address_strobe_n_o;
    endproperty
    property p_rd_held;
        rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o);
    endproperty
    a_req_consumed: assert property (s_taken |=> !req_ready_o)
        else $error("request slot still open after a take");
    a_req_presented: assert property (s_taken |-> s_present)
        else $error("taken request never presented on the bus");
    a_addr_with_strobe: assert property (p_addr_strobe)
        else $error("address moved without a new strobe");
    a_strobe_full_state: assert property (p_strobe_state)
        else $error("strobe shorter than one bus state");
    a_drive_only_write: assert property ($rose(data_oe_o) |-> write_read_o)
        else $error("data pins driven in a read cycle");
    a_hold_no_strobe: assert property (hold_grant_o |-> address_strobe_n_o)
        else $error("strobe asserted while hold granted");
    a_hold_pins_free: assert property (hold_grant_o [*2] |-> !data_oe_o)
        else $error("data pins driven deep in hold");
    a_grant_needs_req: assert property ($rose(hold_grant_o) |-> $past(hold_request_i))
        else $error("hold granted without a request");
    a_grant_stays: assert property (hold_grant_o && hold_request_i |=> hold_grant_o)
        else $error("hold dropped while still requested");
    a_rd_word_held: assert property (p_rd_held)
        else $error("stalled read word lost or changed");
endmodule

bind pbs_seq pbs_seq_checker u_chk (.sys_clk_i, .rst_n_i, .clock_doubled_i,
    .req_valid_i, .req_ready_o, .rd_valid_o, .rd_ready_i, .rd_data_o,
    .hold_request_i, .hold_grant_o, .address_strobe_n_o, .word_address_o,
    .write_read_o, .data_oe_o);

/* tb/pbs_mem_model.sv */
// far-side controller model: acknowledge, next-address and read data
`timescale 1ns/100ps
module pbs_mem_model (
    input  wire logic                       sys_clk_i,
    input  wire logic                       slow_i,
    input  wire logic                       na_en_i,
    input  wire logic                       strobe_n_i,
    input  wire logic [pbs_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                       write_i,
    output logic                            ready_n_o,
    output logic                            na_n_o,
    output logic [pbs_pkg::DATA_W-1:0]      rdata_o
);
    integer                     mseed = 82;
    logic [pbs_pkg::ADDR_W-1:0] rd_addr = '0;
    // only one read is ever in flight, so the last read address
    // presented is the one the acknowledge belongs to
    always @(posedge sys_clk_i)
    begin
        if (!strobe_n_i && !write_i)
            rd_addr <= addr_i;
    end
    assign rdata_o = {~rd_addr[15:0], rd_addr[15:0]};
    // slow mode withholds acknowledge at random, giving wait states
    always @(negedge sys_clk_i)
    begin
        ready_n_o <= slow_i ? (($random(mseed) & 3) != 0) : 1'b0;
        na_n_o <= na_en_i ? (($random(mseed) & 1) == 0) : 1'b1;
    end
endmodule

/* tb/test_pipelined_address_bus_sequencer.sv */
// self-checking bench for the pipelined address bus sequencer
`timescale 1ns/100ps
module test_pipelined_address_bus_sequencer;
    logic        sys_clk_i = 1'b0;
    logic        rst_n_i, clock_doubled_i, req_valid_i, req_ready_o;
    logic        req_write_i, req_mem_i, req_data_cyc_i, rd_valid_o;
    logic        rd_ready_i, next_address_request_n_i, ready_n_i;
    logic        hold_request_i, hold_grant_o, address_strobe_n_o;
    logic        write_read_o, mem_io_o, data_ctrl_o, data_oe_o;
    logic        slow, na_en;
    logic [29:0] req_addr_i, word_address_o;
    logic [3:0]  req_be_n_i, byte_enables_n_o;
    logic [31:0] req_wdata_i, rd_data_o, data_o, data_i, mdata;
    logic [31:0] exp_q[$];
    logic [36:0] bus_q[$];
    logic        ads_q = 1'b1;
    integer      seed = 82;
    integer      err_total = 0;
    integer      n_tests = 0;
    int          n_sent, n_strobe, k, m, n0;

    always #5 sys_clk_i = ~sys_clk_i;
    assign data_i = data_oe_o ? data_o : mdata;

    pbs_seq dut (.sys_clk_i, .rst_n_i, .clock_doubled_i, .req_valid_i,
        .req_ready_o, .req_addr_i, .req_be_n_i, .req_write_i, .req_mem_i,
        .req_data_cyc_i, .req_wdata_i, .rd_valid_o, .rd_ready_i, .rd_data_o,
        .next_address_request_n_i, .ready_n_i, .hold_request_i,
        .hold_grant_o, .address_strobe_n_o, .word_address_o,
        .byte_enables_n_o, .write_read_o, .mem_io_o, .data_ctrl_o, .data_o,
        .data_oe_o, .data_i);
    pbs_mem_model u_mem (.sys_clk_i, .slow_i(slow), .na_en_i(na_en),
        .strobe_n_i(address_strobe_n_o), .addr_i(word_address_o),
        .write_i(write_read_o), .ready_n_o(ready_n_i),
        .na_n_o(next_address_request_n_i), .rdata_o(mdata));

    function automatic logic [31:0] rd_exp(input logic [29:0] a);
        return {~a[15:0], a[15:0]};
    endfunction

    task automatic cmp32(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bus(input string what, input logic [36:0] exp,
                           input logic [36:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // valid stays up between sends so back-to-back offers never glitch
    task automatic send(input logic wr);
        @(negedge sys_clk_i);
        req_addr_i = 30'($random(seed));
        req_write_i = wr;
        req_mem_i = 1'($random(seed));
        req_data_cyc_i = 1'($random(seed));
        req_wdata_i = $random(seed);
        req_be_n_i = wr ? (4'($random(seed)) & 4'he) : 4'h0;
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1)
            @(negedge sys_clk_i);
        @(posedge sys_clk_i);
        n_sent++;
        bus_q.push_back({req_addr_i, req_be_n_i, wr, req_mem_i,
                         req_data_cyc_i});
        if (!wr)
            exp_q.push_back(rd_exp(req_addr_i));
    endtask

    always @(negedge sys_clk_i)
        rd_ready_i <= 1'($random(seed));
    always @(negedge address_strobe_n_o)
        if (rst_n_i)
            n_strobe++;
    // each new strobe must carry the oldest taken request, in order
    always @(negedge sys_clk_i)
    begin
        if (rst_n_i === 1'b1 && ads_q && address_strobe_n_o === 1'b0)
            cmp_bus("address group", bus_q.pop_front(), {word_address_o,
                byte_enables_n_o, write_read_o, mem_io_o, data_ctrl_o});
        ads_q <= address_strobe_n_o;
    end
    always @(posedge sys_clk_i)
        if (rst_n_i && rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
            cmp32("read data", exp_q.pop_front(), rd_data_o);

    initial
    begin
        repeat (60000) @(posedge sys_clk_i);
        err_total++;
        give_verdict();
    end

    initial
    begin
        {rst_n_i, clock_doubled_i, req_valid_i, hold_request_i} = 4'h0;
        {req_write_i, req_mem_i, req_data_cyc_i, slow, na_en} = 5'h0;
        {req_addr_i, req_be_n_i, req_wdata_i} = '0;
        for (m = 0; m < 4; m++)
        begin
            @(negedge sys_clk_i);
            rst_n_i = 1'b0;
            clock_doubled_i = m[1];
            {slow, na_en} = {2{m[0]}};
            repeat (20) @(negedge sys_clk_i);
            cmp32("strobe in reset", 1, address_strobe_n_o);
            n_sent = 0;
            n_strobe = 0;
            bus_q.delete();
            rst_n_i = 1'b1;
            for (k = 0; k < 30; k++)
                send(1'($random(seed)));
            @(negedge sys_clk_i);
            req_valid_i = 1'b0;
            hold_request_i = 1'b1;
            for (k = 0; k < 300 && hold_grant_o !== 1'b1; k++)
                @(negedge sys_clk_i);
            n0 = n_strobe;
            repeat (10) @(negedge sys_clk_i);
            cmp32("hold grant", 1, hold_grant_o);
            cmp32("strobes in hold", n0, n_strobe);
            hold_request_i = 1'b0;
            for (k = 0; k < 12; k++)
                send(1'($random(seed)));
            @(negedge sys_clk_i);
            req_valid_i = 1'b0;
            for (k = 0; k < 500 && exp_q.size() > 0; k++)
                @(negedge sys_clk_i);
            repeat (20) @(negedge sys_clk_i);
            cmp32("bus cycles", n_sent, n_strobe);
            cmp32("reads left", 0, exp_q.size());
            cmp32("cycles left", 0, bus_q.size());
        end
        give_verdict();
    end
endmodule
